//--- crag_defs.svh
`ifndef CRAG_DEFS_SVH
`define CRAG_DEFS_SVH
// Function
// - Two 8-bit accumulators pair as 16 bits.
// - Index plus constant or accumulator forms address.
// - Stack pointer marks last used location.
// - Program counter is a base, not auto-modified.
// - Flags hold five status, two masks, stop-disable.
// - Status flags follow the latest result.
// - Reset fetches vector, sets masks and stop-disable.
// - Words stored high byte at lower address.
// - Any byte address, no alignment fault.
// - Three queued code bytes before each instruction.
// - Lengths of one to seven advance the counter; zero is refused.
// - Internal registers up to 20 bits wide.
// - Direct mode zeroes the upper address byte.
// - Extended mode takes full 16-bit address.
// - Branches add signed 8/16-bit offset.
// - Immediate operand comes from the stream.
// - Signed 5-bit offset needs no extension.
// - Auto modify by one to eight.
// - Accumulator offset of 8 or 16 bits.
// - Signed 9-bit offset, one extension byte.
// - 16-bit offset in two extension bytes.
// - Constant indirect reads pointer, which becomes the operand address.
// - Accumulator indirect reads pointer, which becomes the operand address.
`define CRAG_OFF_D 8'h00
`define CRAG_OFF_X 8'h04
`define CRAG_OFF_Y 8'h08
`define CRAG_OFF_SP 8'h0c
`define CRAG_OFF_PC 8'h10
`define CRAG_OFF_CCR 8'h14
`define CRAG_OFF_CMD 8'h18
`define CRAG_OFF_EA 8'h1c
`define CRAG_OFF_OPND 8'h20
`define CRAG_OFF_STAT 8'h24
`define CRAG_OFF_RES 8'h28
`define CRAG_OFF_XACC 8'h2c
`define CRAG_CCR_RST 8'hd0
`define CRAG_BIT_H 5
`define CRAG_BIT_N 3
`define CRAG_BIT_Z 2
`define CRAG_BIT_V 1
`define CRAG_BIT_C 0
`define CRAG_VEC_ADDR 16'hfffe
`define CRAG_QFULL 2'd3
`define CRAG_STK_STEP 16'h0002
`define CRAG_OKAY 2'b00
`define CRAG_SLVERR 2'b10
`endif

//--- crag_pkg.sv
package crag_pkg;
   typedef enum logic [3:0] {
      inherent_mode = 4'h0,
      immediate_mode = 4'h1,
      direct_mode = 4'h2,
      extended_mode = 4'h3,
      relative_mode = 4'h4,
      indexed_short_mode = 4'h5,
      auto_modify_mode = 4'h6,
      accum_offset_mode = 4'h7,
      indexed_nine_bit_mode = 4'h8,
      indexed_sixteen_bit_mode = 4'h9,
      indirect_const_mode = 4'ha,
      indirect_accum_mode = 4'hb,
      stack_push_mode = 4'hc,
      stack_pull_mode = 4'hd
   } crag_mode_t;
   typedef enum logic [2:0] {
      st_vec_hi = 3'b000,
      st_vec_lo = 3'b001,
      st_idle = 3'b010,
      st_waitq = 3'b011,
      st_ptr_hi = 3'b100,
      st_ptr_lo = 3'b101
   } crag_state_t;
   // Command word, bit 0 upward: mode, base, post, wide, use_b, use_d,
   // step, off5, off9_sign, len, take.
   typedef struct packed {
      logic take;
      logic [2:0] len;
      logic off9_sign;
      logic [4:0] off5;
      logic [3:0] step;
      logic use_d;
      logic use_b;
      logic wide;
      logic post;
      logic [1:0] base;
      crag_mode_t mode;
   } crag_cmd_t;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] sp;
      logic [15:0] pc;
      logic [7:0] condition_flags_reg;
      logic [19:0] xacc;
   } crag_regs_t;
endpackage : crag_pkg

//--- crag_core.sv
`timescale 1ns/1ps
`include "crag_defs.svh"
module crag_core (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic mem_req_o,
   output logic [15:0] mem_addr_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i,
   output logic [15:0] ea_o,
   output logic ea_valid_o,
   output crag_pkg::crag_regs_t regs_o
);
   import crag_pkg::*;

   crag_regs_t regs_ff, nxt_regs;
   crag_state_t state_ff, nxt_state;
   crag_cmd_t cmd_ff;
   logic [7:0] q_ff [0:2];
   logic [1:0] qcnt_ff;
   logic req_ff, stale_ff, err_ff, eav_ff;
   logic [15:0] maddr_ff, ea_ff, opnd_ff, ptr_ff;
   logic [7:0] hi_ff;
   logic aw_have_ff, w_have_ff, awready_ff, wready_ff;
   logic bvalid_ff, arready_ff, rvalid_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff, rd_val;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [15:0] idx_off, ea_calc, want_addr;

   // Byte-lane merge of a write into the old register value.
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Joins two bytes, the one from the lower address on top.
   function automatic logic [15:0] word(input logic [7:0] lo_addr_byte,
                                        input logic [7:0] hi_addr_byte);
      return {lo_addr_byte, hi_addr_byte};
   endfunction : word

   // Tells whether an offset names a register for this access.
   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic wr);
      logic ok;
      ok = (a[1:0] == 2'b00) && (a <= `CRAG_OFF_XACC);
      if (wr && (a == `CRAG_OFF_EA || a == `CRAG_OFF_OPND))
      begin
         ok = 1'b0;
      end
      return ok;
   endfunction : reg_hit

   // Operand datapath terms.
   wire logic [15:0] d_val = {regs_ff.a, regs_ff.b};
   wire logic [15:0] pc_next = regs_ff.pc + {13'h0, cmd_ff.len};
   wire logic [15:0] ext16 = word(q_ff[1], q_ff[2]);
   wire logic [15:0] amt = {13'h0, cmd_ff.step[2:0]} + 16'h0001;
   wire logic [15:0] delta = cmd_ff.step[3] ? 16'h0000 - amt : amt;
   wire logic [15:0] base_val = (cmd_ff.base == 2'd0) ? regs_ff.x :
                                (cmd_ff.base == 2'd1) ? regs_ff.y :
                                (cmd_ff.base == 2'd2) ? regs_ff.sp :
                                pc_next;
   wire logic [15:0] idx_sum = base_val + idx_off;
   wire logic is_auto = cmd_ff.mode == auto_modify_mode;
   wire logic is_ind = cmd_ff.mode == indirect_const_mode ||
                       cmd_ff.mode == indirect_accum_mode;
   wire logic cmd_bad = cmd_ff.len == 3'd0 ||
                        cmd_ff.mode > stack_pull_mode ||
                        (is_auto && cmd_ff.base == 2'd3);
   wire logic exec = state_ff == st_waitq &&
                     qcnt_ff == `CRAG_QFULL;
   wire logic exec_ok = exec && !cmd_bad;

   // Memory side terms.
   wire logic ack = req_ff && mem_ack_i;
   wire logic fetch_st = state_ff == st_idle || state_ff == st_waitq;
   wire logic want = fetch_st ? qcnt_ff != `CRAG_QFULL : 1'b1;

   // Register bus decode.
   wire logic wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
   wire logic wr_ok = wr_go && state_ff == st_idle &&
                      reg_hit(awaddr_ff, 1'b1);
   wire logic ar_take = s_axi_arvalid_i && arready_ff;
   wire logic aw_take = s_axi_awvalid_i && awready_ff;
   wire logic w_take = s_axi_wvalid_i && wready_ff;
   wire logic nxt_aw_have = !wr_go && (aw_have_ff || aw_take);
   wire logic nxt_w_have = !wr_go && (w_have_ff || w_take);
   wire logic nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready_i);
   wire logic w_d = wr_ok && awaddr_ff == `CRAG_OFF_D;
   wire logic w_x = wr_ok && awaddr_ff == `CRAG_OFF_X;
   wire logic w_y = wr_ok && awaddr_ff == `CRAG_OFF_Y;
   wire logic w_sp = wr_ok && awaddr_ff == `CRAG_OFF_SP;
   wire logic w_pc = wr_ok && awaddr_ff == `CRAG_OFF_PC;
   wire logic w_ccr = wr_ok && awaddr_ff == `CRAG_OFF_CCR;
   wire logic w_cmd = wr_ok && awaddr_ff == `CRAG_OFF_CMD;
   wire logic w_st = wr_ok && awaddr_ff == `CRAG_OFF_STAT;
   wire logic w_res = wr_ok && awaddr_ff == `CRAG_OFF_RES;
   wire logic w_xacc = wr_ok && awaddr_ff == `CRAG_OFF_XACC;
   wire logic [31:0] wm_d = merge({16'h0, d_val}, wdata_ff, wstrb_ff);
   wire logic [31:0] wm_x = merge({16'h0, regs_ff.x}, wdata_ff, wstrb_ff);
   wire logic [31:0] wm_y = merge({16'h0, regs_ff.y}, wdata_ff, wstrb_ff);
   wire logic [31:0] wm_sp = merge({16'h0, regs_ff.sp}, wdata_ff,
                                   wstrb_ff);
   wire logic [31:0] wm_pc = merge({16'h0, regs_ff.pc}, wdata_ff,
                                   wstrb_ff);
   wire logic [31:0] wm_ccr = merge({24'h0, regs_ff.condition_flags_reg}, wdata_ff,
                                    wstrb_ff);
   wire logic [31:0] wm_cmd = merge({8'h0, cmd_ff}, wdata_ff, wstrb_ff);
   wire logic [15:0] res = wdata_ff[15:0];
   wire logic res_wide = wdata_ff[16];

   // Offset added to the base in the indexed forms.
   always_comb
   begin
      case (cmd_ff.mode)
         indexed_short_mode: idx_off = {{11{cmd_ff.off5[4]}},
                                        cmd_ff.off5};
         auto_modify_mode: idx_off = cmd_ff.post ? 16'h0000 :
                                     delta;
         accum_offset_mode: idx_off = cmd_ff.use_d ? d_val :
                                      {8'h00, cmd_ff.use_b ? regs_ff.b :
                                       regs_ff.a};
         indexed_nine_bit_mode: idx_off = {{8{cmd_ff.off9_sign}},
                                           q_ff[1]};
         indexed_sixteen_bit_mode: idx_off = ext16;
         indirect_const_mode: idx_off = ext16;
         indirect_accum_mode: idx_off = d_val;
         default: idx_off = 16'h0000;
      endcase
   end

   // Effective address of the operand, or pointer address if indirect.
   always_comb
   begin
      case (cmd_ff.mode)
         immediate_mode: ea_calc = regs_ff.pc + 16'h0001;
         direct_mode: ea_calc = {8'h00, q_ff[1]};
         extended_mode: ea_calc = ext16;
         relative_mode: ea_calc = pc_next + (cmd_ff.wide ? ext16 :
                                  {{8{q_ff[1][7]}}, q_ff[1]});
         stack_push_mode: ea_calc = regs_ff.sp - `CRAG_STK_STEP;
         stack_pull_mode: ea_calc = regs_ff.sp;
         inherent_mode: ea_calc = 16'h0000;
         default: ea_calc = idx_sum;
      endcase
   end

   // Byte address wanted from memory in each state.
   always_comb
   begin
      case (state_ff)
         st_vec_hi: want_addr = `CRAG_VEC_ADDR;
         st_vec_lo: want_addr = `CRAG_VEC_ADDR + 16'h0001;
         st_ptr_hi: want_addr = ptr_ff;
         st_ptr_lo: want_addr = ptr_ff + 16'h0001;
         default: want_addr = regs_ff.pc + {14'h0, qcnt_ff};
      endcase
   end

   // Sequencer: vector load, idle, queue wait, pointer read.
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         st_vec_hi: if (ack) nxt_state = st_vec_lo;
         st_vec_lo: if (ack) nxt_state = st_idle;
         st_idle: if (w_cmd) nxt_state = st_waitq;
         st_waitq: if (exec) nxt_state = (exec_ok && is_ind) ?
                                         st_ptr_hi : st_idle;
         st_ptr_hi: if (ack) nxt_state = st_ptr_lo;
         st_ptr_lo: if (ack) nxt_state = st_idle;
         default: nxt_state = st_vec_hi;
      endcase
   end

   // Programmer-visible register updates.
   always_comb
   begin
      nxt_regs = regs_ff;
      if (w_d)
      begin
         nxt_regs.a = wm_d[15:8];
         nxt_regs.b = wm_d[7:0];
      end
      if (w_x) nxt_regs.x = wm_x[15:0];
      if (w_y) nxt_regs.y = wm_y[15:0];
      if (w_sp) nxt_regs.sp = wm_sp[15:0];
      if (w_pc) nxt_regs.pc = wm_pc[15:0];
      if (w_ccr) nxt_regs.condition_flags_reg = wm_ccr[7:0];
      if (w_res)
      begin
         nxt_regs.condition_flags_reg[`CRAG_BIT_N] = res_wide ? res[15] : res[7];
         nxt_regs.condition_flags_reg[`CRAG_BIT_Z] = res_wide ? res == 16'h0000 :
                                     res[7:0] == 8'h00;
         nxt_regs.condition_flags_reg[`CRAG_BIT_V] = wdata_ff[17];
         nxt_regs.condition_flags_reg[`CRAG_BIT_C] = wdata_ff[18];
         nxt_regs.condition_flags_reg[`CRAG_BIT_H] = wdata_ff[19];
      end
      if (w_xacc)
      begin
         nxt_regs.xacc = wdata_ff[0] ? 20'h00000 :
                         regs_ff.xacc + {4'h0, d_val};
      end
      if (state_ff == st_vec_lo && ack)
      begin
         nxt_regs.pc = word(hi_ff, mem_rdata_i);
      end
      if (exec_ok)
      begin
         nxt_regs.pc = (cmd_ff.mode == relative_mode && cmd_ff.take) ?
                       ea_calc : pc_next;
         if (is_auto)
         begin
            case (cmd_ff.base)
               2'd0: nxt_regs.x = base_val + delta;
               2'd1: nxt_regs.y = base_val + delta;
               default: nxt_regs.sp = base_val + delta;
            endcase
         end
         if (cmd_ff.mode == stack_push_mode) nxt_regs.sp = ea_calc;
         if (cmd_ff.mode == stack_pull_mode)
         begin
            nxt_regs.sp = regs_ff.sp + `CRAG_STK_STEP;
         end
      end
   end

   // Register read mux.
   always_comb
   begin
      case (s_axi_araddr_i)
         `CRAG_OFF_D: rd_val = {16'h0, d_val};
         `CRAG_OFF_X: rd_val = {16'h0, regs_ff.x};
         `CRAG_OFF_Y: rd_val = {16'h0, regs_ff.y};
         `CRAG_OFF_SP: rd_val = {16'h0, regs_ff.sp};
         `CRAG_OFF_PC: rd_val = {16'h0, regs_ff.pc};
         `CRAG_OFF_CCR: rd_val = {24'h0, regs_ff.condition_flags_reg};
         `CRAG_OFF_CMD: rd_val = {8'h0, cmd_ff};
         `CRAG_OFF_EA: rd_val = {16'h0, ea_ff};
         `CRAG_OFF_OPND: rd_val = {16'h0, opnd_ff};
         `CRAG_OFF_STAT: rd_val = {25'h0, state_ff, qcnt_ff, err_ff,
                                   state_ff != st_idle};
         `CRAG_OFF_XACC: rd_val = {12'h0, regs_ff.xacc};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Core state; masks and stop-disable are set before any fetch.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         regs_ff <= '{default: '0, condition_flags_reg: `CRAG_CCR_RST};
         state_ff <= st_vec_hi;
         cmd_ff <= '0;
         err_ff <= 1'b0;
      end
      else
      begin
         regs_ff <= nxt_regs;
         state_ff <= nxt_state;
         if (w_cmd) cmd_ff <= crag_cmd_t'(wm_cmd[23:0]);
         err_ff <= (exec && cmd_bad) ||
                   (err_ff && !(w_st && wstrb_ff[0] && wdata_ff[1]));
      end
   end

   // Instruction queue; flushed on each executed command or new counter.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         qcnt_ff <= 2'd0;
         stale_ff <= 1'b0;
      end
      else
      begin
         stale_ff <= (stale_ff || (w_pc && req_ff)) && !ack;
         if (exec || w_pc || state_ff == st_vec_lo)
         begin
            qcnt_ff <= 2'd0;
         end
         else if (ack && fetch_st && !stale_ff)
         begin
            q_ff[qcnt_ff] <= mem_rdata_i;
            qcnt_ff <= qcnt_ff + 2'd1;
         end
      end
   end

   // Byte request to memory, held until acknowledged.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         req_ff <= 1'b0;
         maddr_ff <= 16'h0000;
      end
      else if (ack)
      begin
         req_ff <= 1'b0;
      end
      else if (!req_ff && want && !w_pc)
      begin
         req_ff <= 1'b1;
         maddr_ff <= want_addr;
      end
   end

   // Address results, pointer capture and immediate operand.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         ea_ff <= 16'h0000;
         eav_ff <= 1'b0;
         opnd_ff <= 16'h0000;
         ptr_ff <= 16'h0000;
         hi_ff <= 8'h00;
      end
      else
      begin
         eav_ff <= (exec_ok && !is_ind) || (state_ff == st_ptr_lo && ack);
         if (exec_ok) ea_ff <= ea_calc;
         if (exec_ok) ptr_ff <= ea_calc;
         if (state_ff == st_ptr_lo && ack)
         begin
            ea_ff <= word(hi_ff, mem_rdata_i);
         end
         if (ack) hi_ff <= mem_rdata_i;
         if (exec_ok && cmd_ff.mode == immediate_mode)
         begin
            opnd_ff <= cmd_ff.wide ? ext16 : {8'h00, q_ff[1]};
         end
      end
   end

   // Register bus handshakes.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `CRAG_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rresp_ff <= `CRAG_OKAY;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         awready_ff <= !nxt_aw_have;
         wready_ff <= !nxt_w_have;
         if (aw_take) awaddr_ff <= s_axi_awaddr_i;
         if (w_take) wdata_ff <= s_axi_wdata_i;
         if (w_take) wstrb_ff <= s_axi_wstrb_i;
         bvalid_ff <= wr_go || (bvalid_ff && !s_axi_bready_i);
         if (wr_go) bresp_ff <= wr_ok ? `CRAG_OKAY : `CRAG_SLVERR;
         rvalid_ff <= nxt_rvalid;
         arready_ff <= !nxt_rvalid;
         if (ar_take)
         begin
            rdata_ff <= reg_hit(s_axi_araddr_i, 1'b0) ? rd_val : 32'h0;
            rresp_ff <= reg_hit(s_axi_araddr_i, 1'b0) ? `CRAG_OKAY :
                        `CRAG_SLVERR;
         end
      end
   end

   // Outputs, each taken from a flip-flop.
   assign s_axi_awready_o = awready_ff;
   assign s_axi_wready_o = wready_ff;
   assign s_axi_bvalid_o = bvalid_ff;
   assign s_axi_bresp_o = bresp_ff;
   assign s_axi_arready_o = arready_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;
   assign mem_req_o = req_ff;
   assign mem_addr_o = maddr_ff;
   assign ea_o = ea_ff;
   assign ea_valid_o = eav_ff;
   assign regs_o = regs_ff;
endmodule : crag_core

//--- crag_mem_model.sv
`timescale 1ns/1ps
module crag_mem_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [15:0] addr_i,
   input wire logic slow_i,
   output logic [7:0] rdata_o,
   output logic ack_o
);
   logic [1:0] wait_ff = 2'd0;
   // Acks a held byte request at once or after three cycles of held request; a
   // released data line toggles so a stale byte never looks valid.
   always @(posedge clk_i)
   begin
      if (req_i && !ack_o && wait_ff == 2'd0)
      begin
         ack_o <= 1'b1;
         rdata_o <= addr_i[7:0] ^ 8'h3c;
         wait_ff <= slow_i ? 2'd3 : 2'd0;
      end
      else
      begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         if (req_i && wait_ff != 2'd0) wait_ff <= wait_ff - 2'd1;
      end
   end
   initial ack_o = 1'b0;
   initial rdata_o = 8'h00;
endmodule : crag_mem_model

//--- crag_core_asserts.sv
`timescale 1ns/1ps
module crag_core_asserts (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic mem_req_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic ea_valid_o,
   input wire crag_pkg::crag_regs_t regs_o
);
   import crag_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // The first fetch after reset is the high byte of the vector.
   a_vec_fetch: assert property (
      $fell(rst_i) |-> ##[0:4] mem_req_o && mem_addr_o == 16'hfffe)
      else $error("Vector fetch did not start at the top word.");
   a_ccr_reset: assert property (
      $fell(rst_i) |-> regs_o.condition_flags_reg == 8'hd0)
      else $error("Flags left reset without masks and stop-disable.");
   a_word_order: assert property (
      mem_req_o && mem_ack_i && mem_addr_o == 16'hfffe
      |-> ##[2:40] mem_req_o && mem_addr_o == 16'hffff)
      else $error("Low vector byte not read after the high byte.");
   a_req_hold: assert property (
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
      else $error("Byte request dropped or moved before its ack.");
   a_req_gap: assert property (
      mem_req_o && mem_ack_i |=> !mem_req_o)
      else $error("Byte request not released after its ack.");
   a_ea_pulse: assert property (
      ea_valid_o |=> !ea_valid_o)
      else $error("Address strobe longer than one cycle.");
   a_b_once: assert property (
      s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("Write response repeated.");
   a_r_once: assert property (
      s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("Read response repeated.");
   // Main scenarios that the bench is expected to reach.
   c_ea: cover property (ea_valid_o);
   c_slow: cover property (mem_req_o && !mem_ack_i ##1 mem_ack_i);
   c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'b10);
endmodule : crag_core_asserts
bind crag_core crag_core_asserts crag_core_asserts_i (.ref_clk_i, .rst_i,
   .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_rvalid_o,
   .s_axi_rready_i, .mem_req_o, .mem_addr_o, .mem_ack_i, .ea_valid_o,
   .regs_o);

//--- crag_core_bench.sv
`timescale 1ns/1ps
module crag_core_bench;
   import crag_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic slow = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, mrd;
   logic [31:0] wd = 32'h0, rdata, d;
   logic awr, wrd, bv, arr, rv, mreq, mack, eav;
   logic [1:0] bresp, rresp;
   logic [15:0] maddr, ea;
   crag_regs_t regs;
   int n_fail = 0, n_checks = 0;
   // Command word, effective address or branch target, X afterwards.
   localparam logic [63:0] tbl [16] = '{
      64'h00300003_3d3e_2000, 64'h00200002_003d_2000,
      64'h0027c005_1fff_2000, 64'h00208035_1004_2000,
      64'h00280008_1f3d_2000, 64'h00300009_5d3e_2000,
      64'h00200207_3234_2000, 64'h00200107_2034_2000,
      64'h00203c06_1ff8_1ff8, 64'h00200046_2000_2001,
      64'h0030000a_0203_2000, 64'h0020000b_0809_2000,
      64'h0010000c_fffe_2000, 64'h00a00004_103f_2000,
      64'h00b00084_4d41_2000, 64'h00200001_1001_2000};
   // Free-running core clock.
   always #2 ref_clk_i = ~ref_clk_i;
   crag_core crag_core_i (.ref_clk_i, .rst_i, .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rr), .mem_req_o(mreq), .mem_addr_o(maddr),
      .mem_rdata_i(mrd), .mem_ack_i(mack), .ea_o(ea), .ea_valid_o(eav),
      .regs_o(regs));
   crag_mem_model crag_mem_model_i (.clk_i(ref_clk_i), .req_i(mreq),
      .addr_i(maddr), .slow_i(slow), .rdata_o(mrd), .ack_o(mack));
   task automatic final_report();
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] er);
      logic ad, dd;
      @(posedge ref_clk_i);
      ad = 1'b0;
      dd = 1'b0;
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!(ad && dd))
      begin
         @(posedge ref_clk_i);
         if (awv && awr) ad = 1'b1;
         if (wv && wrd) dd = 1'b1;
         if (ad) awv <= 1'b0;
         if (dd) wv <= 1'b0;
      end
      do @(posedge ref_clk_i); while (bv !== 1'b1);
      br <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge ref_clk_i);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge ref_clk_i); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge ref_clk_i); while (rv !== 1'b1);
      rr <= 1'b0;
      d = rdata;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd
   // Polls status until idle with a full queue.
   task automatic idle();
      int k;
      k = 0;
      do
      begin
         rd(8'h24, 2'b00);
         k++;
      end
      while ((d[0] !== 1'b0 || d[6:2] !== 5'h0b) && k < 100);
      chk("queue", 32'h3, {30'h0, d[3:2]});
      chk("state", 32'h2, {29'h0, d[6:4]});
   endtask : idle
   task automatic cmd(input logic [31:0] c, input logic [15:0] e, xe);
      wr(8'h10, 32'h1000, 2'b00);
      wr(8'h04, 32'h2000, 2'b00);
      wr(8'h0c, 32'h0, 2'b00);
      idle();
      wr(8'h18, c, 2'b00);
      idle();
      if (c[3:0] == 4'h4)
         chk("branch", {16'h0, e}, {16'h0, regs.pc});
      else
      begin
         chk("ea", {16'h0, e}, {16'h0, ea});
         chk("pc", 32'h1000 + c[22:20], {16'h0, regs.pc});
      end
      chk("x", {16'h0, xe}, {16'h0, regs.x});
      if (c[3:0] == 4'h1)
      begin
         rd(8'h20, 2'b00);
         chk("opnd", 32'h3d, d);
      end
   endtask : cmd
   task automatic t_reset();
      chk("ccr", 32'hd0, {24'h0, regs.condition_flags_reg});
      rst_i <= 1'b0;
      idle();
      chk("vector", 32'hc2c3, {16'h0, regs.pc});
   endtask : t_reset
   task automatic t_regs();
      wr(8'h00, 32'h1234, 2'b00);
      chk("a", 32'h12, {24'h0, regs.a});
      chk("b", 32'h34, {24'h0, regs.b});
      rd(8'h00, 2'b00);
      chk("d", 32'h1234, d);
      wr(8'h1c, 32'h1, 2'b10);
      rd(8'h3c, 2'b10);
   endtask : t_regs
   task automatic t_modes();
      logic [63:0] t;
      for (int s = 0; s < 2; s++)
      begin
         slow <= s[0];
         foreach (tbl[i])
         begin
            t = tbl[i];
            cmd(t[63:32], t[31:16], t[15:0]);
         end
      end
   endtask : t_modes
   task automatic t_refuse();
      wr(8'h10, 32'h1000, 2'b00);
      idle();
      wr(8'h18, 32'h200036, 2'b00);
      idle();
      chk("err", 32'h1, {31'h0, d[1]});
      chk("pc", 32'h1000, {16'h0, regs.pc});
      wr(8'h24, 32'h2, 2'b00);
   endtask : t_refuse
   task automatic t_flags();
      wr(8'h28, 32'h90000, 2'b00);
      chk("ccr", 32'hf4, {24'h0, regs.condition_flags_reg});
      wr(8'h28, 32'h20080, 2'b00);
      chk("ccr", 32'hda, {24'h0, regs.condition_flags_reg});
      wr(8'h00, 32'hffff, 2'b00);
      wr(8'h2c, 32'h1, 2'b00);
      wr(8'h2c, 32'h0, 2'b00);
      wr(8'h2c, 32'h0, 2'b00);
      chk("xacc", 32'h1fffe, {12'h0, regs.xacc});
   endtask : t_flags
   // Runs the scenarios after twenty cycles of reset.
   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      t_reset();
      t_regs();
      t_modes();
      t_refuse();
      t_flags();
      final_report();
   end
   // Cuts a hung run short.
   initial
   begin
      repeat (60000) @(posedge ref_clk_i);
      n_fail++;
      final_report();
   end
endmodule : crag_core_bench
